// ===== rtl/flash_seq_pkg.sv
// constants and types shared by the erase/program sequencer
package flash_seq_pkg;
  localparam int ADDR_W = 32;
  localparam int NUM_BLK = 512;
  localparam int BLK_W = 9;
  localparam logic [7:0] CMD_UNLOCK = 8'h06;
  localparam logic [7:0] CMD_SECTOR = 8'h20;
  localparam logic [7:0] CMD_HALF = 8'h52;
  localparam logic [7:0] CMD_BLOCK = 8'hd8;
  localparam logic [7:0] CMD_ARRAY = 8'h60;
  localparam logic [7:0] CMD_PAGE = 8'h02;
  localparam logic [7:0] CMD_QPAGE = 8'h38;
  localparam logic [7:0] CMD_STATUS = 8'h05;
  localparam int CLK_MHZ = 50;
  localparam int SECTOR_WIPE_TIME_US = 30;
  localparam int HALF_BLOCK_WIPE_TIME_US = 150;
  localparam int BLOCK_WIPE_TIME_US = 300;
  localparam int ARRAY_WIPE_TIME_US = 1000;
  localparam int PAGE_WRITE_TIME_US = 10;
  localparam int SECTOR_WIPE_CYC = SECTOR_WIPE_TIME_US * CLK_MHZ;
  localparam int HALF_BLOCK_WIPE_CYC = HALF_BLOCK_WIPE_TIME_US * CLK_MHZ;
  localparam int BLOCK_WIPE_CYC = BLOCK_WIPE_TIME_US * CLK_MHZ;
  localparam int ARRAY_WIPE_CYC = ARRAY_WIPE_TIME_US * CLK_MHZ;
  localparam int PAGE_WRITE_CYC = PAGE_WRITE_TIME_US * CLK_MHZ;
  localparam int TIMER_W = 24;
  localparam int BYTE_CNT_W = 9;

  typedef enum logic [2:0] {
    OP_SECTOR = 3'h0,
    OP_HALF = 3'h1,
    OP_BLOCK = 3'h2,
    OP_ARRAY = 3'h3,
    OP_PAGE = 3'h4
  } op_t;

  // one started self-timed operation, handed to the array side
  typedef struct packed {
    op_t op;
    logic [ADDR_W-1:0] addr;
    logic [8:0] nbytes;
  } job_t;

  typedef struct packed {
    logic scheme_sel;
    logic [3:0] bp;
    logic quad_en;
    logic four_line_command_mode;
  } prot_cfg_t;
endpackage

// ===== rtl/flash_cycle_timer.sv
// self-timed cycle counter driving the busy flag
`timescale 1ns/100ps
module flash_cycle_timer
  import flash_seq_pkg::*;
#(
  parameter int W = TIMER_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [W-1:0] cycles_i,
  output logic busy_o,
  output logic done_o
);
  logic [W-1:0] cnt_q;
  logic busy_q;
  logic done_q;
  wire last = busy_q && (cnt_q <= W'(1));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= last;
      if (start_i && !busy_q) begin
        cnt_q <= cycles_i;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        cnt_q <= cnt_q - W'(1);
        if (last) busy_q <= 1'b0;
      end
    end
  end

  assign busy_o = busy_q;
  assign done_o = done_q;
endmodule

// ===== rtl/flash_erase_program_sequencer.sv
// serial flash wipe and page write command sequencer
`timescale 1ns/100ps
module flash_erase_program_sequencer
  import flash_seq_pkg::*;
#(
  parameter int SECTOR_CYC = SECTOR_WIPE_CYC,
  parameter int HALF_CYC = HALF_BLOCK_WIPE_CYC,
  parameter int BLOCK_CYC = BLOCK_WIPE_CYC,
  parameter int ARRAY_CYC = ARRAY_WIPE_CYC,
  parameter int PAGE_CYC = PAGE_WRITE_CYC
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic chip_select_n_i,
  input wire logic sclk_i,
  input wire logic [3:0] sio_i,
  output logic [3:0] sio_o,
  output logic [3:0] sio_oe_o,
  input wire flash_seq_pkg::prot_cfg_t cfg_i,
  input wire logic [NUM_BLK-1:0] persistent_sector_guard_i,
  output logic busy_flag_o,
  output logic write_unlock_latch_o,
  output logic [NUM_BLK-1:0] volatile_sector_guard_o,
  output flash_seq_pkg::job_t job_o,
  output logic job_valid_o,
  output logic page_we_o,
  output logic [7:0] page_waddr_o,
  output logic [7:0] page_wdata_o,
  output logic [BLK_W-1:0] skip_blk_o,
  output logic skip_blk_valid_o
);
  import flash_seq_pkg::*;

  logic [1:0] rst_sync_q;
  wire rst_n = rst_sync_q[1];
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) rst_sync_q <= 2'b00;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  // pins cross in two stages; only stage two is read
  logic [1:0] cs_s_q;
  logic [1:0] sck_s_q;
  logic [3:0] sio_s1_q;
  logic [3:0] sio_s2_q;
  logic sck_d1_q;
  logic cs_d1_q;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cs_s_q <= 2'b11;
      sck_s_q <= 2'b00;
      sio_s1_q <= 4'h0;
      sio_s2_q <= 4'h0;
      sck_d1_q <= 1'b0;
      cs_d1_q <= 1'b1;
    end else begin
      cs_s_q <= {cs_s_q[0], chip_select_n_i};
      sck_s_q <= {sck_s_q[0], sclk_i};
      sio_s1_q <= sio_i;
      sio_s2_q <= sio_s1_q;
      sck_d1_q <= sck_s_q[1];
      cs_d1_q <= cs_s_q[1];
    end
  end
  wire cs_n = cs_s_q[1];
  wire sck_rise = sck_s_q[1] && !sck_d1_q && !cs_n;
  wire cs_rise = cs_n && !cs_d1_q;
  wire cs_fall = !cs_n && cs_d1_q;

  typedef enum logic [4:0] {
    ST_CMD = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_DATA = 5'b00100,
    ST_STAT = 5'b01000,
    ST_IGN = 5'b10000
  } frame_t;
  frame_t st_q;

  logic [7:0] sh_q;
  logic [2:0] bitc_q;
  logic [2:0] bytec_q;
  logic [7:0] cmd_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] off_q;
  logic [8:0] nbytes_q;
  logic quad_q;
  logic [7:0] stat_sh_q;

  // lane width: quad command phase, or quad page write
  wire wide = cfg_i.four_line_command_mode || quad_q;
  wire [2:0] bits_per = wide ? 3'd4 : 3'd1;
  wire [7:0] sh_nx = wide ? {sh_q[3:0], sio_s2_q}
                          : {sh_q[6:0], sio_s2_q[0]};
  wire byte_done = sck_rise && (bitc_q + bits_per == 3'd0);
  wire at_boundary = (bitc_q == 3'd0);

  function automatic logic is_addr_cmd(input logic [7:0] c);
    return c == CMD_SECTOR || c == CMD_HALF || c == CMD_BLOCK ||
           c == CMD_PAGE || c == CMD_QPAGE;
  endfunction

  function automatic logic blk_guarded(input logic [BLK_W-1:0] b,
                                       input logic [3:0] bp,
                                       input logic sel,
                                       input logic [NUM_BLK-1:0] persistent_sector_guard,
                                       input logic [NUM_BLK-1:0] volatile_sector_guard);
    logic [BLK_W:0] span;
    span = (bp == 4'h0) ? '0 : (BLK_W+1)'(1) << (bp - 4'h1);
    if (sel) return persistent_sector_guard[b] || volatile_sector_guard[b];
    return (bp != 4'h0) && ({1'b0, b} >= (BLK_W+1)'(NUM_BLK) - span);
  endfunction

  logic wel_q;
  logic busy;
  logic done;
  logic start_q;
  logic [TIMER_W-1:0] cyc_q;
  job_t job_q;
  logic job_v_q;
  logic [NUM_BLK-1:0] dpb_q;
  logic dpb_init_q;

  wire [BLK_W-1:0] tgt_blk = addr_q[BLK_W+15:16];
  wire tgt_guard = blk_guarded(tgt_blk, cfg_i.bp, cfg_i.scheme_sel,
                               persistent_sector_guard_i, dpb_q);
  wire can_write = wel_q && !busy && !job_v_q;
  wire addr_ok = (st_q == ST_DATA) && (bytec_q == 3'd0) && at_boundary;
  wire data_ok = (st_q == ST_DATA) && at_boundary &&
                 (nbytes_q != 9'd0);
  wire cmd_only = (st_q == ST_ADDR) && (bytec_q == 3'd0) && at_boundary;

  wire go_wipe = cs_rise && can_write && addr_ok && !tgt_guard &&
                 (cmd_q == CMD_SECTOR || cmd_q == CMD_HALF ||
                  cmd_q == CMD_BLOCK);
  wire go_page = cs_rise && can_write && data_ok && !tgt_guard &&
                 (cmd_q == CMD_PAGE || cmd_q == CMD_QPAGE);
  wire any_guard = cfg_i.scheme_sel ? |(persistent_sector_guard_i | dpb_q)
                                    : 1'b0;
  wire go_array = cs_rise && can_write && cmd_only &&
                  cmd_q == CMD_ARRAY &&
                  (cfg_i.scheme_sel || cfg_i.bp == 4'h0);
  wire go_unlock = cs_rise && cmd_only && cmd_q == CMD_UNLOCK && !busy;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_CMD;
      sh_q <= 8'h00;
      bitc_q <= 3'd0;
      bytec_q <= 3'd0;
      cmd_q <= 8'h00;
      addr_q <= '0;
      off_q <= 8'h00;
      nbytes_q <= 9'd0;
      quad_q <= 1'b0;
    end else if (cs_fall || cs_n) begin
      st_q <= ST_CMD;
      bitc_q <= 3'd0;
      bytec_q <= 3'd0;
      nbytes_q <= 9'd0;
      quad_q <= 1'b0;
    end else if (sck_rise) begin
      sh_q <= sh_nx;
      bitc_q <= bitc_q + bits_per;
      if (byte_done) begin
        unique case (st_q)
          ST_CMD: begin
            cmd_q <= sh_nx;
            quad_q <= (sh_nx == CMD_QPAGE) && cfg_i.quad_en;
            st_q <= sh_nx == CMD_STATUS ? ST_STAT
                  : (is_addr_cmd(sh_nx) || sh_nx == CMD_ARRAY ||
                     sh_nx == CMD_UNLOCK) ? ST_ADDR : ST_IGN;
            bytec_q <= is_addr_cmd(sh_nx) ? 3'd4 : 3'd0;
          end
          ST_ADDR: begin
            if (bytec_q == 3'd0) st_q <= ST_IGN; // stray bits void
            else begin
              addr_q <= {addr_q[ADDR_W-9:0], sh_nx};
              bytec_q <= bytec_q - 3'd1;
              if (bytec_q == 3'd1) begin
                st_q <= ST_DATA;
                off_q <= sh_nx;
              end
            end
          end
          ST_DATA: begin
            if (is_addr_cmd(cmd_q) && (cmd_q == CMD_PAGE ||
                cmd_q == CMD_QPAGE)) begin
              off_q <= off_q + 8'd1;
              if (nbytes_q != 9'd256) nbytes_q <= nbytes_q + 9'd1;
            end else st_q <= ST_IGN;
          end
          default: ;
        endcase
      end
    end
  end

  // page buffer writes wrap in the page; later bytes overwrite earlier
  logic pwe_q;
  logic [7:0] pwa_q;
  logic [7:0] pwd_q;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pwe_q <= 1'b0;
      pwa_q <= 8'h00;
      pwd_q <= 8'h00;
    end else begin
      pwe_q <= byte_done && st_q == ST_DATA && can_write &&
               (cmd_q == CMD_PAGE || cmd_q == CMD_QPAGE);
      pwa_q <= off_q;
      pwd_q <= sh_nx;
    end
  end

  // msb stands before the first data clock; advance only after the
  // host has sampled, so the sync delay never skips a bit
  wire [7:0] stat_val = {6'h00, wel_q, busy};
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) stat_sh_q <= 8'h00;
    else if (st_q != ST_STAT) stat_sh_q <= stat_val;
    else if (sck_rise) begin
      stat_sh_q <= cfg_i.four_line_command_mode ? {stat_sh_q[3:0], stat_sh_q[7:4]}
                             : {stat_sh_q[6:0], stat_sh_q[7]};
    end
  end
  logic [3:0] sio_q;
  logic [3:0] oe_q;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sio_q <= 4'h0;
      oe_q <= 4'h0;
    end else begin
      sio_q <= cfg_i.four_line_command_mode ? stat_sh_q[7:4] : {2'b00, stat_sh_q[7], 1'b0};
      oe_q <= (st_q == ST_STAT && !cs_n) ?
              (cfg_i.four_line_command_mode ? 4'hf : 4'h2) : 4'h0;
    end
  end

  wire [TIMER_W-1:0] cyc_sel =
      cmd_q == CMD_SECTOR ? TIMER_W'(SECTOR_CYC) :
      cmd_q == CMD_HALF ? TIMER_W'(HALF_CYC) :
      cmd_q == CMD_BLOCK ? TIMER_W'(BLOCK_CYC) :
      cmd_q == CMD_ARRAY ? TIMER_W'(ARRAY_CYC) : TIMER_W'(PAGE_CYC);
  wire op_t op_sel = cmd_q == CMD_SECTOR ? OP_SECTOR :
                     cmd_q == CMD_HALF ? OP_HALF :
                     cmd_q == CMD_BLOCK ? OP_BLOCK :
                     cmd_q == CMD_ARRAY ? OP_ARRAY : OP_PAGE;
  // region base: any address in the region selects it
  wire [ADDR_W-1:0] base = cmd_q == CMD_SECTOR ? {addr_q[31:12], 12'h000} :
                           cmd_q == CMD_HALF ? {addr_q[31:15], 15'h0000} :
                           cmd_q == CMD_BLOCK ? {addr_q[31:16], 16'h0000} :
                           cmd_q == CMD_ARRAY ? '0 :
                           {addr_q[31:8], 8'h00};

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wel_q <= 1'b0;
      start_q <= 1'b0;
      cyc_q <= '0;
      job_q <= '0;
      job_v_q <= 1'b0;
    end else begin
      start_q <= go_wipe || go_page || go_array;
      if (go_wipe || go_page || go_array) begin
        cyc_q <= cyc_sel;
        job_q <= '{op: op_sel, addr: base, nbytes: nbytes_q};
        job_v_q <= 1'b1;
      end else if (start_q) job_v_q <= 1'b0;
      if (go_unlock) wel_q <= 1'b1;
      else if (done) wel_q <= 1'b0;
    end
  end

  flash_cycle_timer #(
    .W(TIMER_W)
  ) u_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .start_i(start_q),
    .cycles_i(cyc_q),
    .busy_o(busy),
    .done_o(done)
  );

  // array wipe in scheme 1 walks the blocks and flags guarded ones
  logic [BLK_W-1:0] walk_q;
  logic walking_q;
  logic skip_v_q;
  logic [BLK_W-1:0] skip_q;
  wire walk_guard = blk_guarded(walk_q, cfg_i.bp, 1'b1,
                                persistent_sector_guard_i, dpb_q);
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      walk_q <= '0;
      walking_q <= 1'b0;
      skip_v_q <= 1'b0;
      skip_q <= '0;
    end else begin
      skip_v_q <= walking_q && walk_guard && any_guard;
      skip_q <= walk_q;
      if (go_array && cfg_i.scheme_sel) begin
        walking_q <= 1'b1;
        walk_q <= '0;
      end else if (walking_q) begin
        walk_q <= walk_q + BLK_W'(1);
        if (walk_q == BLK_W'(NUM_BLK - 1)) walking_q <= 1'b0;
      end
    end
  end

  // volatile guards all set on the first clock after reset in scheme 1, all clear in scheme 0
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dpb_q <= '0;
      dpb_init_q <= 1'b0;
    end else if (!dpb_init_q) begin
      dpb_init_q <= 1'b1;
      dpb_q <= cfg_i.scheme_sel ? '1 : '0;
    end
  end

  logic busy_q;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) busy_q <= 1'b0;
    else busy_q <= busy || start_q || job_v_q;
  end

  assign sio_o = sio_q;
  assign sio_oe_o = oe_q;
  assign busy_flag_o = busy_q;
  assign write_unlock_latch_o = wel_q;
  assign volatile_sector_guard_o = dpb_q;
  assign job_o = job_q;
  assign job_valid_o = job_v_q;
  assign page_we_o = pwe_q;
  assign page_waddr_o = pwa_q;
  assign page_wdata_o = pwd_q;
  assign skip_blk_o = skip_q;
  assign skip_blk_valid_o = skip_v_q;
endmodule

// ===== verif/flash_host_model.sv
// host-side serial flash controller model driving the link pins
`timescale 1ns/100ps
module flash_host_model (
  output logic chip_select_n_o,
  output logic sclk_o,
  output logic [3:0] sio_o,
  input wire logic [3:0] line_i
);
  initial begin
    chip_select_n_o = 1'b1;
    sclk_o = 1'b0;
    sio_o = 4'h0;
  end
  // odd offset keeps the link phase apart from clk
  task automatic start();
    #37 chip_select_n_o = 1'b0;
    #80;
  endtask
  // mode 0, msb first; idle lines toggle so they carry nothing
  task automatic put(input logic [7:0] b, input int n, input bit q,
                     output logic [7:0] r);
    for (int i = 0; i < n; i++) begin
      if (q) sio_o = b[7-4*i -: 4];
      else sio_o = {{3{i[0]}}, b[7-i]};
      #80 sclk_o = 1'b1;
      r = {r[6:0], line_i[1]};
      #80 sclk_o = 1'b0;
    end
  endtask
  // released lines do not keep their last value
  task automatic stop();
    #40 chip_select_n_o = 1'b1;
    sio_o = ~sio_o;
    #600;
  endtask
endmodule

// ===== verif/flash_erase_program_sequencer_props.sv
// port-level assertions for the wipe/write sequencer
`timescale 1ns/100ps
module flash_erase_program_sequencer_props
  import flash_seq_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic chip_select_n_i,
  input wire logic [3:0] sio_oe_o,
  input wire flash_seq_pkg::prot_cfg_t cfg_i,
  input wire logic [NUM_BLK-1:0] persistent_sector_guard_i,
  input wire logic busy_flag_o,
  input wire logic write_unlock_latch_o,
  input wire logic [NUM_BLK-1:0] volatile_sector_guard_o,
  input wire flash_seq_pkg::job_t job_o,
  input wire logic job_valid_o,
  input wire logic page_we_o,
  input wire logic [7:0] page_waddr_o,
  input wire logic skip_blk_valid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic seen_q;
  logic [7:0] nxt_q;
  wire [BLK_W-1:0] blk = job_o.addr[24:16];
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      seen_q <= 1'b0;
      nxt_q <= 8'h00;
    end else begin
      seen_q <= !chip_select_n_i && (seen_q || page_we_o);
      if (page_we_o) nxt_q <= page_waddr_o + 8'h01;
    end
  end
  sequence s_deselected;
    chip_select_n_i [*6];
  endsequence
  sequence s_job_start;
    !job_valid_o ##1 job_valid_o;
  endsequence
  AST_LATCH_BEFORE_BUSY: assert property ($rose(busy_flag_o) |-> $past(write_unlock_latch_o)) else $error("busy without latch");
  AST_BUSY_ON_DESELECT: assert property ($rose(busy_flag_o) |-> $past(chip_select_n_i, 2)) else $error("busy before deselect");
  AST_LATCH_CLEARS: assert property ($fell(busy_flag_o) |-> ##[0:2] !write_unlock_latch_o) else $error("latch kept");
  AST_JOB_STARTS_CYCLE: assert property (s_job_start |-> ##[0:3] busy_flag_o) else $error("job without busy");
  AST_NO_JOB_WHILE_BUSY: assert property (s_job_start |-> !$past(busy_flag_o, 2)) else $error("job while busy");
  AST_STATUS_ONE_LINE: assert property (sio_oe_o != 4'h0 && !cfg_i.four_line_command_mode |-> sio_oe_o == 4'h2) else $error("wrong status line");
  AST_RELEASED: assert property (s_deselected |-> sio_oe_o == 4'h0) else $error("drives while deselected");
  AST_PAGE_WRAP: assert property (page_we_o && seen_q |-> page_waddr_o == nxt_q) else $error("page address step");
  AST_ARRAY_GUARD0: assert property (s_job_start ##0
      (job_o.op == OP_ARRAY && !cfg_i.scheme_sel) |-> cfg_i.bp == 4'h0)
    else $error("guarded array wipe");
  AST_SKIP_SCHEME1: assert property (skip_blk_valid_o |-> cfg_i.scheme_sel) else $error("skip in scheme 0");
  AST_GUARD_TARGET: assert property (s_job_start ##0
      (cfg_i.scheme_sel && job_o.op != OP_ARRAY) |->
      !(volatile_sector_guard_o[blk] || persistent_sector_guard_i[blk]))
    else $error("guarded target");
  AST_POWERUP_GUARDS: assert property ($rose(arst_n_i) && cfg_i.scheme_sel |-> ##4 (&volatile_sector_guard_o)) else $error("guards not set");
endmodule
bind flash_erase_program_sequencer flash_erase_program_sequencer_props
  flash_erase_program_sequencer_props_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .chip_select_n_i(chip_select_n_i), .sio_oe_o(sio_oe_o), .cfg_i(cfg_i),
  .persistent_sector_guard_i(persistent_sector_guard_i),
  .busy_flag_o(busy_flag_o), .write_unlock_latch_o(write_unlock_latch_o),
  .volatile_sector_guard_o(volatile_sector_guard_o), .job_o(job_o),
  .job_valid_o(job_valid_o), .page_we_o(page_we_o),
  .page_waddr_o(page_waddr_o), .skip_blk_valid_o(skip_blk_valid_o));

// ===== verif/flash_erase_program_sequencer_test.sv
// self-checking bench for the wipe/write sequencer
`timescale 1ns/100ps
module flash_erase_program_sequencer_test;
  import flash_seq_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  prot_cfg_t cfg = '0;
  logic [NUM_BLK-1:0] psg = '0;
  logic cs_n, sclk, busy, write_unlock_latch, jv, jv_q, pwe, skv;
  logic [3:0] host_sio, dev_sio, dev_oe, line;
  logic [NUM_BLK-1:0] vsg;
  logic [7:0] pwa, pwd;
  logic [7:0] mem [256];
  logic [BLK_W-1:0] skb;
  job_t job, last_job;
  int errors = 0, n_checks = 0, njobs = 0, nskip = 0;
  assign line = (dev_oe & dev_sio) | (~dev_oe & host_sio);
  initial forever #10 clk = ~clk;
  flash_host_model flash_host_model_i (.chip_select_n_o(cs_n),
    .sclk_o(sclk), .sio_o(host_sio), .line_i(line));
  flash_erase_program_sequencer #(.SECTOR_CYC(2000), .HALF_CYC(300),
    .BLOCK_CYC(300), .ARRAY_CYC(300), .PAGE_CYC(300))
    flash_erase_program_sequencer_i (.clk_i(clk), .arst_n_i(arst_n),
    .chip_select_n_i(cs_n), .sclk_i(sclk), .sio_i(line), .sio_o(dev_sio),
    .sio_oe_o(dev_oe), .cfg_i(cfg), .persistent_sector_guard_i(psg),
    .busy_flag_o(busy), .write_unlock_latch_o(write_unlock_latch),
    .volatile_sector_guard_o(vsg), .job_o(job), .job_valid_o(jv),
    .page_we_o(pwe), .page_waddr_o(pwa), .page_wdata_o(pwd),
    .skip_blk_o(skb), .skip_blk_valid_o(skv));
  always @(posedge clk) begin
    jv_q <= jv;
    if (jv && !jv_q) begin
      njobs++;
      last_job = job;
    end
    if (pwe) mem[pwa] = pwd;
    if (skv) begin
      chk("skip blk", 32'(nskip), 32'(skb));
      nskip++;
    end
  end
  function automatic logic [7:0] dat(input int i);
    return 8'(i) ^ 8'h5a;
  endfunction
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic do_reset(input bit s);
    arst_n <= 1'b0;
    cfg <= {s, 6'h00};
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (10) @(posedge clk);
  endtask
  task automatic frame(input logic [7:0] c, input logic [31:0] a,
                       input int na, nd, input bit qc, q, input int ex);
    logic [7:0] r;
    flash_host_model_i.start();
    flash_host_model_i.put(c, qc ? 2 : 8, qc, r);
    for (int i = 0; i < na; i++) flash_host_model_i.put(a[31-8*i -: 8], q ? 2 : 8, q, r);
    for (int i = 0; i < nd; i++) flash_host_model_i.put(dat(i), q ? 2 : 8, q, r);
    if (ex > 0) flash_host_model_i.put(8'h0f, ex, 1'b0, r);
    flash_host_model_i.stop();
  endtask
  task automatic settle();
    for (int k = 0; k < 20000 && busy !== 1'b0; k++) @(posedge clk);
    chk("idle", 0, busy);
  endtask
  task automatic run(input string w, input logic [7:0] c, input logic [31:0] a,
                     input int na, nd, input bit qc, q, input int ex,
                     input bit acc, input logic [31:0] ea, input op_t eo);
    int j;
    j = njobs;
    frame(CMD_UNLOCK, 0, 0, 0, qc, 1'b0, 0);
    frame(c, a, na, nd, qc, q, ex);
    chk(w, 32'(acc), 32'(njobs - j));
    if (acc) begin
      chk(w, eo, last_job.op);
      if (eo < OP_ARRAY) chk(w, ea, last_job.addr);
      settle();
      chk(w, 0, write_unlock_latch);
    end
  endtask
  task automatic t_locked_status();
    logic [7:0] r;
    frame(CMD_SECTOR, 32'h00012345, 4, 0, 0, 0, 0);
    chk("locked", 0, njobs + busy);
    frame(CMD_UNLOCK, 0, 0, 0, 0, 0, 0);
    frame(CMD_SECTOR, 32'h00012345, 4, 0, 0, 0, 0);
    flash_host_model_i.start();
    flash_host_model_i.put(CMD_STATUS, 8, 1'b0, r);
    flash_host_model_i.put(8'h00, 8, 1'b0, r);
    flash_host_model_i.stop();
    chk("status busy", 1, r[0]);
    frame(CMD_UNLOCK, 0, 0, 0, 0, 0, 0);
    frame(CMD_SECTOR, 32'h00020000, 4, 0, 0, 0, 0);
    chk("busy refuse", 1, njobs);
    settle();
  endtask
  task automatic t_wipes();
    run("sector", CMD_SECTOR, 32'h0001abcd, 4, 0, 0, 0, 0, 1, 32'h0001a000, OP_SECTOR);
    run("half", CMD_HALF, 32'h0001abcd, 4, 0, 0, 0, 0, 1, 32'h00018000, OP_HALF);
    run("block", CMD_BLOCK, 32'h0001abcd, 4, 0, 0, 0, 0, 1, 32'h00010000, OP_BLOCK);
    run("sector odd", CMD_SECTOR, 32'h00001000, 4, 0, 0, 0, 3, 0, 0, OP_SECTOR);
    run("array odd", CMD_ARRAY, 0, 0, 0, 0, 0, 4, 0, 0, OP_ARRAY);
    @(posedge clk) cfg.bp <= 4'h1;
    run("array bp", CMD_ARRAY, 0, 0, 0, 0, 0, 0, 0, 0, OP_ARRAY);
    run("sector bp", CMD_SECTOR, 32'h01ff0000, 4, 0, 0, 0, 0, 0, 0, OP_SECTOR);
    run("page bp", CMD_PAGE, 32'h01ff0100, 4, 1, 0, 0, 0, 0, 0, OP_PAGE);
    @(posedge clk) cfg.bp <= 4'h0;
    run("array", CMD_ARRAY, 0, 0, 0, 0, 0, 0, 1, 0, OP_ARRAY);
  endtask
  task automatic t_pages();
    run("page", CMD_PAGE, 32'h00000ffe, 4, 4, 0, 0, 0, 1, 0, OP_PAGE);
    chk("page n", 4, last_job.nbytes);
    for (int i = 0; i < 4; i++) chk("page wrap", dat(i), mem[8'(254 + i)]);
    run("page odd", CMD_PAGE, 32'h00000100, 4, 2, 0, 0, 5, 0, 0, OP_PAGE);
    @(posedge clk) cfg.quad_en <= 1'b1;
    run("quad", CMD_QPAGE, 0, 4, 258, 0, 1, 0, 1, 0, OP_PAGE);
    chk("quad n", 256, last_job.nbytes);
    chk("quad last", {dat(256), dat(257), dat(2)}, {mem[0], mem[1], mem[2]});
    @(posedge clk) cfg.four_line_command_mode <= 1'b1;
    run("qpi", CMD_BLOCK, 32'h00230000, 4, 0, 1, 1, 0, 1, 32'h00230000, OP_BLOCK);
  endtask
  task automatic t_scheme1();
    do_reset(1'b1);
    chk("guards", 1, &vsg);
    run("sector s1", CMD_SECTOR, 32'h00010000, 4, 0, 0, 0, 0, 0, 0, OP_SECTOR);
    frame(CMD_UNLOCK, 0, 0, 0, 0, 0, 0);
    frame(CMD_ARRAY, 0, 0, 0, 0, 0, 0);
    settle();
    repeat (600) @(posedge clk);
    chk("skipped", NUM_BLK, nskip);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #1000000;
    errors++;
    tally_and_finish();
  end
  initial begin
    do_reset(1'b0);
    t_locked_status();
    t_wipes();
    t_pages();
    t_scheme1();
    tally_and_finish();
  end
endmodule
